/* File: nwg_pkg.sv */
package nwg_pkg;
   // bus geometry
   localparam int AXI_AW = 12;
   localparam int IDX_W = 10;
   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_GIC = 10'h00b;
   localparam logic [IDX_W-1:0] IDX_FLG = 10'h00d;
   localparam logic [IDX_W-1:0] IDX_ENB = 10'h08d;
   localparam logic [IDX_W-1:0] IDX_DLO = 10'h10c;
   localparam logic [IDX_W-1:0] IDX_ALO = 10'h10d;
   localparam logic [IDX_W-1:0] IDX_DHI = 10'h10e;
   localparam logic [IDX_W-1:0] IDX_AHI = 10'h10f;
   localparam logic [IDX_W-1:0] IDX_CTL = 10'h18c;
   localparam logic [IDX_W-1:0] IDX_UNL = 10'h18d;
   // control register fields
   localparam int CTL_SEL_BIT = 7;
   localparam int CTL_ERR_BIT = 3;
   localparam int CTL_WEL_BIT = 2;
   localparam int CTL_WR_BIT = 1;
   localparam int CTL_RD_BIT = 0;
   // event flag and enable fields
   localparam int FLG_DONE_BIT = 4;
   localparam int FLG_REFUSE_BIT = 0;
   // implemented bits per register
   localparam logic [7:0] AHI_MASK = 8'h07;
   localparam logic [7:0] DHI_MASK = 8'h3f;
   localparam logic [7:0] FLG_MASK = 8'h11;
   // reset values
   localparam logic [7:0] GIC_RST = 8'h00;
   localparam logic [7:0] FLG_RST = 8'h00;
   localparam logic [7:0] ENB_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   // unlock keys
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
   // timing
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned PUD_MS = 72;
   localparam int unsigned PUD_CYCLES = PUD_MS * (CLK_HZ / 1000);
   localparam int unsigned WRITE_CYCLES = 8;
   localparam int unsigned READ_CYCLES = 2;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // configuration word, a one means unprotected or allowed
   typedef struct packed {
      logic data_protect_n;
      logic code_protect_hi;
      logic code_protect_lo;
      logic flash_write_permit;
   } nwg_cfg_t;
   localparam nwg_cfg_t CFG_ERASED = 4'hf;
   localparam nwg_cfg_t CFG_LOCKED = 4'h0;
   // requests from the serial programming port decoder
   typedef struct packed {
      logic erase;
      logic cfg_prog;
      nwg_cfg_t cfg_val;
   } nwg_prog_req_t;
   // request towards the memory arrays
   typedef struct packed {
      logic wr;
      logic rd;
      logic prog;
      logic [10:0] addr;
      logic [13:0] wdata;
   } nwg_mem_req_t;
endpackage

/* File: nwg_delay_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module nwg_delay_timer import nwg_pkg::*; #(
   parameter int unsigned COUNT = PUD_CYCLES
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // status
   output logic done_o
);
   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

   logic [CW-1:0] cnt_r; // cycles elapsed since power-up
   logic done_r; // delay has run out

   // count once after reset, then hold done
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         done_r <= 1'b0;
      end else if (!done_r) begin
         cnt_r <= cnt_r + 1'b1;
         done_r <= (cnt_r == LAST);
      end
   end

   assign done_o = done_r;
endmodule
`default_nettype wire

/* File: nwg_cfg_store.sv */
`timescale 1ns/1ps
`default_nettype none
module nwg_cfg_store import nwg_pkg::*; (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // programmer side and stored word
   input wire nwg_prog_req_t prog_req_i,
   input wire nwg_cfg_t cfg_nv_i,
   // live configuration
   output nwg_cfg_t cfg_o,
   output logic loaded_o
);
   nwg_cfg_t cfg_r; // working copy of the configuration word
   logic loaded_r; // copy taken from the array after reset

   // only the programmer port reaches this store, core software cannot
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_r <= CFG_LOCKED;
         loaded_r <= 1'b0;
      end else if (!loaded_r) begin
         cfg_r <= cfg_nv_i;
         loaded_r <= 1'b1;
      end else if (prog_req_i.erase) begin
         cfg_r <= CFG_ERASED;
      end else if (prog_req_i.cfg_prog) begin
         cfg_r <= cfg_r & prog_req_i.cfg_val;
      end
   end

   assign cfg_o = cfg_r;
   assign loaded_o = loaded_r;
endmodule
`default_nettype wire

/* File: nwg_gate.sv */
// Summary of operation
// - power-up clears the write enable latch
// - no eeprom write during power-up delay
// - write needs latch and completed unlock
// - start blocked unless latch set earlier
// - completion clears start, sets done flag
// - flash write refused when permit is 0
// - user code cannot alter configuration bits
// - any protection disables external port access
// - core eeprom access ignores data protection
// - data protection also blocks program access
// - access returns only after erase, unprotect
// - core flash fetch and read always allowed
// - external access only when all three protection bits 1
// - configuration bits set again only by full erase
// - unlock location stores nothing
`timescale 1ns/1ps
`default_nettype none
module nwg_gate import nwg_pkg::*; #(
   parameter int unsigned PUD_CYC = PUD_CYCLES,
   parameter int unsigned WR_CYC = WRITE_CYCLES
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // axi4-lite write address and data
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // programming port and configuration array
   input wire nwg_prog_req_t prog_req_i,
   input wire nwg_cfg_t cfg_nv_i,
   output nwg_cfg_t cfg_o,
   output logic ext_access_o,
   // memory arrays
   output nwg_mem_req_t mem_req_o,
   input wire logic [13:0] mem_rdata_i,
   // interrupt
   output logic irq_o
);
   localparam logic [15:0] WR_LAST = 16'(WR_CYC - 1);
   localparam logic [15:0] RD_LAST = 16'(READ_CYCLES - 1);

   typedef enum logic [1:0] {UNL_IDLE, UNL_GOT1, UNL_ARMED} nwg_unl_t;
   typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} nwg_op_t;

   // bus handshake state
   logic aw_ready_r; // write address and data taken together
   logic b_valid_r; // write response pending
   logic [1:0] b_resp_r; // write response code
   logic ar_ready_r; // read address taken
   logic r_valid_r; // read data pending
   logic [1:0] r_resp_r; // read response code
   logic [31:0] r_data_r; // read data
   // software registers
   logic [7:0] gic_r; // global interrupt control
   logic [7:0] flg_r; // sticky event flags
   logic [7:0] enb_r; // event enables, interrupt mask
   logic [7:0] dlo_r; // data low byte
   logic [7:0] dhi_r; // data high byte
   logic [7:0] alo_r; // address low byte
   logic [7:0] ahi_r; // address high byte
   logic sel_r; // program space select
   logic err_r; // write error flag
   logic wel_r; // write enable latch
   logic wr_r; // write start, busy while writing
   logic rd_r; // read start, busy while reading
   // sequencing
   nwg_unl_t unl_r; // unlock progress
   nwg_unl_t unl_nxt;
   nwg_op_t op_r; // current access
   nwg_op_t op_nxt;
   logic [15:0] cnt_r; // cycles spent in the current access
   // outputs held in flops
   nwg_mem_req_t mem_req_r;
   logic ext_r;
   logic irq_r;
   // helpers
   logic power_up_delay_timer_done; // power-up delay has run out
   logic cfg_loaded; // configuration copy valid
   nwg_cfg_t cfg; // live configuration

   // index of a byte address, or all ones when not word aligned
   function automatic logic [IDX_W-1:0] idx_of(input logic [AXI_AW-1:0] a);
      idx_of = (a[1:0] == 2'b00) ? a[AXI_AW-1:2] : '1;
   endfunction

   // true when the index names a register
   function automatic logic mapped(input logic [IDX_W-1:0] i);
      mapped = (i == IDX_GIC) || (i == IDX_FLG) || (i == IDX_ENB) ||
               (i == IDX_DLO) || (i == IDX_ALO) || (i == IDX_DHI) ||
               (i == IDX_AHI) || (i == IDX_CTL) || (i == IDX_UNL);
   endfunction

   // power-up delay timer
   nwg_delay_timer #(
      .COUNT(PUD_CYC)
   ) u_pud (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .done_o(power_up_delay_timer_done)
   );

   // configuration word, reachable from the programmer port only
   nwg_cfg_store u_cfg (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .prog_req_i(prog_req_i),
      .cfg_nv_i(cfg_nv_i),
      .cfg_o(cfg),
      .loaded_o(cfg_loaded)
   );

   // write decode
   wire wr_en = s_axi_awvalid & s_axi_wvalid & aw_ready_r;
   wire [IDX_W-1:0] widx = idx_of(s_axi_awaddr);
   wire wr_hit = wr_en & mapped(widx) & s_axi_wstrb[0];
   wire [7:0] wdat = s_axi_wdata[7:0];
   wire ctl_wr = wr_hit & (widx == IDX_CTL);
   wire unl_wr = wr_hit & (widx == IDX_UNL);
   wire flg_wr = wr_hit & (widx == IDX_FLG);

   // read decode
   wire rd_en = s_axi_arvalid & ar_ready_r;
   wire [IDX_W-1:0] ridx = idx_of(s_axi_araddr);
   wire flg_rd = rd_en & (ridx == IDX_FLG);

   // control register as read back
   wire [7:0] ctl_val = {sel_r, 3'b000, err_r, wel_r, wr_r, rd_r};

   // read data selection, the unlock location reads zero
   wire [7:0] rd_mux =
      (ridx == IDX_GIC) ? gic_r :
      (ridx == IDX_FLG) ? flg_r :
      (ridx == IDX_ENB) ? enb_r :
      (ridx == IDX_DLO) ? dlo_r :
      (ridx == IDX_ALO) ? alo_r :
      (ridx == IDX_DHI) ? dhi_r :
      (ridx == IDX_AHI) ? ahi_r :
      (ridx == IDX_CTL) ? ctl_val : 8'h00;

   // start requests and their permission
   wire idle = (op_r == OP_IDLE);
   wire wr_req = ctl_wr & wdat[CTL_WR_BIT] & idle;
   wire tgt_prog = wdat[CTL_SEL_BIT];
   // eeprom writes wait for the power-up delay
   wire data_ok = power_up_delay_timer_done;
   // flash writes need the permit bit only, protection bits ignored
   wire prog_ok = cfg_loaded & cfg.flash_write_permit;
   // latch value before this write, unlock armed, target allowed
   wire wr_ok = wel_r & (unl_r == UNL_ARMED) &
                (tgt_prog ? prog_ok : data_ok);
   wire wr_go = wr_req & wr_ok;
   wire wr_refused = wr_req & ~wr_ok;
   // core reads are never gated by protection
   wire rd_go = ctl_wr & wdat[CTL_RD_BIT] & idle & ~wr_req;
   wire wr_end = (op_r == OP_WRITE) & (cnt_r == WR_LAST);
   wire rd_end = (op_r == OP_READ) & (cnt_r == RD_LAST);

   // unlock sequence, any other register write breaks it
   always_comb begin
      unl_nxt = unl_r;
      if (unl_wr) begin
         if (wdat == UNLOCK_KEY1) begin
            unl_nxt = UNL_GOT1;
         end else if (wdat == UNLOCK_KEY2 && unl_r == UNL_GOT1) begin
            unl_nxt = UNL_ARMED;
         end else begin
            unl_nxt = UNL_IDLE;
         end
      end else if (wr_hit) begin
         unl_nxt = UNL_IDLE;
      end
   end

   // access sequencer
   always_comb begin
      op_nxt = op_r;
      unique case (op_r)
         OP_IDLE: begin
            if (wr_go) begin
               op_nxt = OP_WRITE;
            end else if (rd_go) begin
               op_nxt = OP_READ;
            end
         end
         OP_READ: begin
            if (rd_end) begin
               op_nxt = OP_IDLE;
            end
         end
         OP_WRITE: begin
            if (wr_end) begin
               op_nxt = OP_IDLE;
            end
         end
      endcase
   end

   // flags: hardware set wins over read clear and software write
   wire [7:0] flg_set = (8'(wr_end) << FLG_DONE_BIT) |
                        (8'(wr_refused) << FLG_REFUSE_BIT);
   wire [7:0] flg_base = flg_wr ? (wdat & FLG_MASK) :
                         flg_rd ? 8'h00 : flg_r;
   wire [7:0] flg_nxt = flg_base | flg_set;

   // axi write channel, address and data taken in one edge
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_ready_r <= 1'b0;
         b_valid_r <= 1'b0;
         b_resp_r <= RESP_OKAY;
      end else begin
         aw_ready_r <= s_axi_awvalid & s_axi_wvalid & ~aw_ready_r & ~b_valid_r;
         if (wr_en) begin
            b_valid_r <= 1'b1;
            b_resp_r <= mapped(widx) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            b_valid_r <= 1'b0;
         end
      end
   end

   // axi read channel
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ar_ready_r <= 1'b0;
         r_valid_r <= 1'b0;
         r_resp_r <= RESP_OKAY;
         r_data_r <= '0;
      end else begin
         ar_ready_r <= s_axi_arvalid & ~ar_ready_r & ~r_valid_r;
         if (rd_en) begin
            r_valid_r <= 1'b1;
            r_resp_r <= mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
            r_data_r <= {24'h000000, rd_mux};
         end else if (s_axi_rready) begin
            r_valid_r <= 1'b0;
         end
      end
   end

   // plain storage registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gic_r <= GIC_RST;
         enb_r <= ENB_RST;
         alo_r <= ADDR_RST;
         ahi_r <= ADDR_RST;
      end else if (wr_hit) begin
         if (widx == IDX_GIC) gic_r <= wdat;
         if (widx == IDX_ENB) enb_r <= wdat & FLG_MASK;
         if (widx == IDX_ALO) alo_r <= wdat;
         if (widx == IDX_AHI) ahi_r <= wdat & AHI_MASK;
      end
   end

   // data bytes, loaded by software or by a finished read
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dlo_r <= DATA_RST;
         dhi_r <= DATA_RST;
      end else if (rd_end) begin
         dlo_r <= mem_rdata_i[7:0];
         dhi_r <= sel_r ? {2'b00, mem_rdata_i[13:8]} : 8'h00;
      end else if (wr_hit && widx == IDX_DLO) begin
         dlo_r <= wdat;
      end else if (wr_hit && widx == IDX_DHI) begin
         dhi_r <= wdat & DHI_MASK;
      end
   end

   // control bits; the latch is cleared by power-up reset
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_r <= 1'b0;
         wel_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         if (ctl_wr && idle) begin
            sel_r <= wdat[CTL_SEL_BIT];
         end
         if (ctl_wr) begin
            wel_r <= wdat[CTL_WEL_BIT];
         end
         // refused start sets the error flag, set wins over clear
         err_r <= wr_refused | (ctl_wr ? wdat[CTL_ERR_BIT] : err_r);
      end
   end

   // busy bits follow the sequencer, cleared by hardware at the end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
      end else begin
         wr_r <= (op_nxt == OP_WRITE);
         rd_r <= (op_nxt == OP_READ);
      end
   end

   // sequencer state and cycle counter
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_r <= OP_IDLE;
         unl_r <= UNL_IDLE;
         cnt_r <= '0;
      end else begin
         op_r <= op_nxt;
         unl_r <= unl_nxt;
         cnt_r <= (op_nxt == op_r && !idle) ? cnt_r + 16'h0001 : 16'h0000;
      end
   end

   // memory request held for the whole access
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_req_r <= '0;
      end else begin
         mem_req_r.wr <= (op_nxt == OP_WRITE);
         mem_req_r.rd <= (op_nxt == OP_READ);
         if (idle) begin
            mem_req_r.prog <= wdat[CTL_SEL_BIT];
            mem_req_r.addr <= {ahi_r[2:0], alo_r};
            mem_req_r.wdata <= {dhi_r[5:0], dlo_r};
         end
      end
   end

   // flags, external access gate and interrupt
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flg_r <= FLG_RST;
         ext_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         flg_r <= flg_nxt;
         // any active protection shuts the programming port out
         ext_r <= cfg_loaded & cfg.code_protect_hi &
                  cfg.code_protect_lo & cfg.data_protect_n;
         irq_r <= |(flg_nxt & enb_r);
      end
   end

   // outputs
   assign s_axi_awready = aw_ready_r;
   assign s_axi_wready = aw_ready_r;
   assign s_axi_bvalid = b_valid_r;
   assign s_axi_bresp = b_resp_r;
   assign s_axi_arready = ar_ready_r;
   assign s_axi_rvalid = r_valid_r;
   assign s_axi_rresp = r_resp_r;
   assign s_axi_rdata = r_data_r;
   assign mem_req_o = mem_req_r;
   assign ext_access_o = ext_r;
   assign irq_o = irq_r;
   assign cfg_o = cfg;
endmodule
`default_nettype wire

/* File: nwg_gate_props.sv */
`timescale 1ns/1ps
`default_nettype none
module nwg_gate_props import nwg_pkg::*; #(
   parameter int unsigned PUD_CYC = PUD_CYCLES,
   parameter int unsigned WR_CYC = WRITE_CYCLES
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // bus handshakes
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // configuration and memory side
   input wire nwg_prog_req_t prog_req_i,
   input wire nwg_cfg_t cfg_o,
   input wire logic ext_access_o,
   input wire nwg_mem_req_t mem_req_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   int unsigned up_cnt_r; // cycles since reset release, saturating
   int unsigned wr_cnt_r; // width of the current write pulse
   wire logic unprot = cfg_o.code_protect_hi & cfg_o.code_protect_lo & cfg_o.data_protect_n;
   // time since reset and write pulse width
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         up_cnt_r <= 0;
         wr_cnt_r <= 0;
      end else begin
         up_cnt_r <= (up_cnt_r < PUD_CYC) ? up_cnt_r + 1 : up_cnt_r;
         wr_cnt_r <= mem_req_o.wr ? wr_cnt_r + 1 : 0;
      end
   end
   a_ext_open: assert property (unprot |=> ext_access_o)
      else $error("port access not granted while unprotected");
   a_ext_closed: assert property (!unprot |=> !ext_access_o)
      else $error("port access granted while protected");
   a_erase_opens: assert property (prog_req_i.erase |=> cfg_o == CFG_ERASED)
      else $error("erase left configuration protected");
   a_cfg_held: assert property (!prog_req_i.erase && !prog_req_i.cfg_prog
      && !$past(rst_i) |=> $stable(cfg_o))
      else $error("configuration changed without programmer");
   a_cfg_no_rise: assert property (prog_req_i.cfg_prog && !prog_req_i.erase
      |=> (cfg_o & ~$past(cfg_o)) == 4'h0)
      else $error("configuration bit set without erase");
   a_wr_len: assert property ($fell(mem_req_o.wr) |-> wr_cnt_r == WR_CYC)
      else $error("write pulse has wrong length");
   a_flash_permit: assert property ($rose(mem_req_o.wr) && mem_req_o.prog
      |-> cfg_o.flash_write_permit)
      else $error("flash write without permit");
   a_powerup_hold: assert property ($rose(mem_req_o.wr) && !mem_req_o.prog
      |-> up_cnt_r >= PUD_CYC)
      else $error("eeprom write during power-up delay");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   c_ee_write: cover property ($rose(mem_req_o.wr) && !mem_req_o.prog);
   c_fl_write: cover property ($rose(mem_req_o.wr) && mem_req_o.prog);
   c_erase: cover property (prog_req_i.erase);
endmodule
bind nwg_gate nwg_gate_props #(.PUD_CYC(PUD_CYC), .WR_CYC(WR_CYC)) props_u (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .prog_req_i(prog_req_i),
   .cfg_o(cfg_o), .ext_access_o(ext_access_o), .mem_req_o(mem_req_o));
`default_nettype wire

/* File: nwg_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nwg_mem_model import nwg_pkg::*; (
   // clock
   input wire logic sys_clk_i,
   // request in, read data out
   input wire nwg_mem_req_t mem_req_i,
   output logic [13:0] rdata_o
);
   logic [13:0] cell_r [0:4095]; // cells by space and address
   logic [13:0] idle_r = 14'h2a5a; // changing pattern when not read
   initial begin
      for (int k = 0; k < 4096; k++) begin
         cell_r[k] = 14'h0000;
      end
   end
   // store writes, scramble the idle bus
   always @(posedge sys_clk_i) begin
      idle_r <= ~idle_r + 14'h0001;
      if (mem_req_i.wr) begin
         cell_r[{mem_req_i.prog, mem_req_i.addr}] <= mem_req_i.wdata;
      end
   end
   // reads ignore protection
   assign rdata_o = mem_req_i.rd ? cell_r[{mem_req_i.prog, mem_req_i.addr}] : idle_r;
endmodule
`default_nettype wire

/* File: nwg_gate_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module nwg_gate_bench import nwg_pkg::*;;
   typedef struct packed {logic [1:0] r; logic [31:0] d; logic [31:0] m;} nwg_exp_t;
   localparam int unsigned PUD_SIM = 40; // shortened power-up delay
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'h1;
   logic awready, wready, bvalid, arready, rvalid, ext, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [13:0] mrd, v;
   logic [10:0] a;
   nwg_prog_req_t preq = '0;
   nwg_cfg_t cfg_nv = CFG_ERASED;
   nwg_cfg_t cfg;
   nwg_mem_req_t mreq;
   nwg_exp_t rq[$], e;
   logic [1:0] bq[$];
   int n_errors = 0, num_checks = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   nwg_gate #(.PUD_CYC(PUD_SIM), .WR_CYC(8)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .prog_req_i(preq), .cfg_nv_i(cfg_nv), .cfg_o(cfg), .ext_access_o(ext),
      .mem_req_o(mreq), .mem_rdata_i(mrd), .irq_o(irq));
   nwg_mem_model mem_u (.sys_clk_i(sys_clk_i), .mem_req_i(mreq), .rdata_o(mrd));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // bus write, response noted for the monitor
   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                     input logic [1:0] er = RESP_OKAY);
      bq.push_back(er);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge sys_clk_i); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge sys_clk_i); while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   // bus read, masked expectation noted for the monitor
   task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                     input logic [7:0] m = 8'hff, input logic [1:0] er = RESP_OKAY);
      rq.push_back({er, 24'h0, d & m, (er == RESP_OKAY) ? {24'hff_ffff, m} : 32'h0});
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk_i); while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   // unlock keys then the control write
   task automatic start(input logic [7:0] ctl);
      wr(IDX_UNL, UNLOCK_KEY1);
      wr(IDX_UNL, UNLOCK_KEY2);
      wr(IDX_CTL, ctl);
   endtask
   // one programming port action
   task automatic prog(input logic er, input logic [3:0] cv);
      preq <= {er, ~er, cv};
      @(posedge sys_clk_i);
      preq <= '0;
      repeat (3) @(posedge sys_clk_i);
   endtask
   // wait for completion interrupt, bounded
   task automatic wait_done;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk({31'h0, irq}, 32'h1);
   endtask
   // monitor: compare each answer with the oldest note
   always @(posedge sys_clk_i) begin
      if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
         e = rq.pop_front();
         chk(rdata & e.m, e.d);
         chk({30'h0, rresp}, {30'h0, e.r});
      end
      if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0) begin
         chk({30'h0, bresp}, {30'h0, bq.pop_front()});
      end
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_errors++;
      report_and_stop;
   end
   initial begin
      void'($urandom(94243));
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      // start attempted inside the power-up delay
      wr(IDX_CTL, 8'h04);
      start(8'h06);
      rd(IDX_CTL, 8'h0c, 8'h0e);
      rd(IDX_FLG, 8'h01, 8'h11);
      chk({31'h0, irq}, 32'h0);
      rd(IDX_FLG, 8'h00, 8'h11);
      rd(IDX_ENB, 8'h00);
      wr(IDX_UNL, 8'h5a);
      rd(IDX_UNL, 8'h00);
      rd(10'h3ff, 8'h00, 8'h00, RESP_SLVERR);
      wr(10'h3ff, 8'h12, RESP_SLVERR);
      repeat (PUD_SIM) @(posedge sys_clk_i);
      // wrong key order, foreign write between keys, latch set with start
      for (int k = 0; k < 3; k++) begin
         wr(IDX_CTL, (k == 2) ? 8'h00 : 8'h04);
         wr(IDX_UNL, (k == 0) ? UNLOCK_KEY2 : UNLOCK_KEY1);
         if (k == 1) wr(IDX_ALO, 8'h00);
         wr(IDX_UNL, (k == 0) ? UNLOCK_KEY1 : UNLOCK_KEY2);
         wr(IDX_CTL, 8'h06);
         rd(IDX_CTL, 8'h00, 8'h02);
      end
      // write without lane 0 is ignored
      wstrb <= 4'h0;
      wr(IDX_ENB, 8'h10);
      wstrb <= 4'h1;
      rd(IDX_ENB, 8'h00);
      wr(IDX_ENB, 8'h10);
      rd(IDX_FLG, 8'h01, 8'h11);
      // eeprom then flash write, read back
      for (int s = 0; s < 2; s++) begin
         v = 14'($urandom);
         a = 11'($urandom);
         wr(IDX_ALO, a[7:0]);
         wr(IDX_AHI, {5'h0, a[10:8]});
         wr(IDX_DLO, v[7:0]);
         wr(IDX_DHI, {2'b00, v[13:8]});
         wr(IDX_GIC, v[7:0]);
         rd(IDX_GIC, v[7:0]);
         wr(IDX_CTL, {s[0], 7'h04});
         start({s[0], 7'h06});
         wait_done;
         rd(IDX_CTL, {s[0], 7'h04}, 8'h86);
         rd(IDX_FLG, 8'h10, 8'h11);
         chk({31'h0, irq}, 32'h0);
         wr(IDX_DLO, ~v[7:0]);
         if (s == 1) prog(1'b0, 4'h1);
         wr(IDX_CTL, {s[0], 7'h01});
         repeat (4) @(posedge sys_clk_i);
         rd(IDX_DLO, v[7:0]);
         rd(IDX_DHI, (s == 1) ? {2'b00, v[13:8]} : 8'h00);
      end
      // flash write with permit cleared
      prog(1'b0, 4'h0);
      wr(IDX_CTL, 8'h84);
      start(8'h86);
      rd(IDX_CTL, 8'h00, 8'h02);
      rd(IDX_FLG, 8'h01, 8'h01);
      // software write sets only the implemented flag bits
      wr(IDX_FLG, 8'hff);
      rd(IDX_FLG, 8'h11);
      // every configuration after erase
      for (int i = 0; i < 16; i++) begin
         prog(1'b1, 4'h0);
         chk({28'h0, cfg}, {28'h0, CFG_ERASED});
         prog(1'b0, 4'(i));
         prog(1'b0, 4'hf);
         chk({28'h0, cfg}, 32'(i));
         chk({31'h0, ext}, {31'h0, &i[3:1]});
      end
      // reset in mid-run, locked stored word
      wr(IDX_CTL, 8'h04);
      cfg_nv <= CFG_LOCKED;
      rst_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      chk({28'h0, cfg}, 32'h0);
      chk({31'h0, ext}, 32'h0);
      rd(IDX_CTL, 8'h00, 8'h04);
      report_and_stop;
   end
endmodule
`default_nettype wire
